// File: jtag_debug_event_port_test.sv
// jtag_debug_event_port_test: self-checking bench for jtdp_top with the controller model.
// assumes the bench plays the core: it answers halt requests and supplies readback data.
`timescale 1ns/1ps
module jtag_debug_event_port_test;
    import jtdp_pkg::*;
    localparam int DR_W = 24;
    logic            clk, rstn, tck, tms, tdi, trst_n, tdo, tdo_oe, q;
    logic            de_out_n, de_oe, de_drive_n, de_wire_n;
    logic            core_in_debug, core_halt_req, dbg_cmd_valid;
    logic [DR_W-1:0] dbg_rsp_data, dbg_cmd_data, cap;
    int              mismatches, samples_checked, cmd_cycles;

    // pull-up on the debug event pin unless some party pulls it low
    assign de_wire_n = ~((de_oe & ~de_out_n) | ~de_drive_n);

    jtdp_top #(.DR_W(DR_W)) jtdp_top_inst (.clk(clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .debug_event_pin_in_n(de_wire_n),
        .debug_event_pin_out_n(de_out_n), .debug_event_pin_oe(de_oe), .core_in_debug(core_in_debug),
        .core_halt_req(core_halt_req), .dbg_rsp_data(dbg_rsp_data), .dbg_cmd_valid(dbg_cmd_valid),
        .dbg_cmd_data(dbg_cmd_data));
    jtdp_ctl_model jtdp_ctl_model_inst (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
        .de_drive_n(de_drive_n), .tdo(tdo), .tdo_oe(tdo_oe));

    initial clk = 1'b0;
    always #4 clk = ~clk;

    // ==============================================================
    // helpers
    task automatic check(input logic [DR_W-1:0] got, input logic [DR_W-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // from idle through capture and n shift bits, back to idle
    task automatic shift(input logic ir, input logic [DR_W-1:0] v, input int n, output logic [DR_W-1:0] c);
        logic b;
        c = '0;
        jtdp_ctl_model_inst.step(1'b1, 1'b1, b);
        if (ir)
            jtdp_ctl_model_inst.step(1'b1, 1'b1, b);
        jtdp_ctl_model_inst.step(1'b0, 1'b1, b);
        jtdp_ctl_model_inst.step(1'b0, 1'b1, b);
        for (int i = 0; i < n; i++) begin
            jtdp_ctl_model_inst.step(i == n - 1, v[i], b);
            c[i] = b;
        end
        jtdp_ctl_model_inst.step(1'b1, 1'b1, b);
        jtdp_ctl_model_inst.step(1'b0, 1'b1, b);
        repeat (6) @(posedge clk);
        #1;
        check(tdo_oe, 1'b0);
    endtask

    // the pin pulse length is counted on the wire itself
    task automatic enter_debug();
        int hits;
        hits = 0;
        core_in_debug = 1'b1;
        repeat (8) begin
            @(posedge clk);
            #1;
            if (de_oe === 1'b1 && de_wire_n === 1'b0)
                hits++;
        end
        check(hits, 3);
        check(core_halt_req, 1'b0);
    endtask

    // ==============================================================
    // monitors
    always @(posedge clk) begin
        if (dbg_cmd_valid === 1'b1)
            cmd_cycles++;
    end

    // a tdo change must trail a tck fall, never a rise
    always @(tdo) begin
        realtime dt;
        #0.1;
        dt = $realtime - jtdp_ctl_model_inst.fall_t;
        if (rstn === 1'b1 && tdo_oe === 1'b1)
            check(dt > 16.0 && dt < 48.0, 1'b1);
    end

    initial begin
        #200000;
        mismatches++;
        wrap_up();
    end

    // ==============================================================
    // scenarios
    task automatic trst_abort();
        jtdp_ctl_model_inst.step(1'b1, 1'b1, q);
        jtdp_ctl_model_inst.step(1'b0, 1'b1, q);
        jtdp_ctl_model_inst.step(1'b0, 1'b1, q);
        jtdp_ctl_model_inst.step(1'b1, 1'b1, q);
        jtdp_ctl_model_inst.step(1'b0, 1'b1, q);
        jtdp_ctl_model_inst.step(1'b0, 1'b1, q);
        check(q, 1'bz);
        jtdp_ctl_model_inst.step(1'b1, 1'b1, q);
        jtdp_ctl_model_inst.step(1'b0, 1'b1, q);
        jtdp_ctl_model_inst.step(1'b0, 1'b1, q);
        check(tdo_oe, 1'b1);
        jtdp_ctl_model_inst.trst_pulse();
        check(tdo_oe, 1'b0);
        jtdp_ctl_model_inst.step(1'b0, 1'b1, q);
        shift(1'b0, 24'h0000b4, 8, cap);
        check(cap[7:0], 8'h68);
    endtask

    task automatic pin_request();
        jtdp_ctl_model_inst.de_pulse(4);
        check(core_halt_req, 1'b1);
        repeat (3) @(posedge clk);
        #1;
        enter_debug();
        jtdp_ctl_model_inst.de_pulse(4);
        repeat (4) @(posedge clk);
        #1;
        check(core_halt_req, 1'b0);
        core_in_debug = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        check(core_halt_req, 1'b0);
    endtask

    initial begin
        rstn = 1'b0;
        core_in_debug = 1'b0;
        dbg_rsp_data = 24'hc35a96;
        mismatches = 0;
        samples_checked = 0;
        cmd_cycles = 0;
        repeat (10) @(posedge clk);
        #1;
        check({tdo_oe, de_oe, de_out_n, core_halt_req, dbg_cmd_valid}, 5'b00100);
        repeat (2) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        jtdp_ctl_model_inst.trst_pulse();
        jtdp_ctl_model_inst.step(1'b0, 1'b1, q);
        shift(1'b1, {20'h0, IR_DBG_CMD}, IR_W, cap);
        check(cap[3:0], IR_CAPTURE);
        shift(1'b0, 24'h3e91b7, DR_W, cap);
        check(cap, 24'hc35a96);
        check(cmd_cycles, 1);
        check(dbg_cmd_data, 24'h3e91b7);
        trst_abort();
        check(cmd_cycles, 1);
        pin_request();
        shift(1'b1, {20'h0, IR_DBG_REQ}, IR_W, cap);
        check(core_halt_req, 1'b1);
        repeat (3) @(posedge clk);
        #1;
        enter_debug();
        core_in_debug = 1'b0;
        wrap_up();
    end
endmodule

// File: jtdp_ctl_model.sv
// jtdp_ctl_model: outside test and debug controller for the test pins and debug event pin.
// assumes its tasks are entered just after a rising core clock edge.
`timescale 1ns/1ps
module jtdp_ctl_model (
    input  wire logic clk,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trst_n,
    output logic      de_drive_n,
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    realtime fall_t;

    // ==============================================================
    // idle levels: pulled-up lines high, tck parked low between frames
    initial begin
        tck        = 1'b0;
        tms        = 1'b1;
        tdi        = 1'b1;
        trst_n     = 1'b1;
        de_drive_n = 1'b1;
        fall_t     = -1000.0;
    end

    // ==============================================================
    // one test clock period of 64 ns, tdo taken late in the high phase
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        repeat (4) @(posedge clk);
        #1 tck = 1'b1;
        repeat (4) @(posedge clk);
        #1 q = tdo_oe ? tdo : 1'bz;
        tck = 1'b0;
        fall_t = $realtime;
    endtask

    // no tck edges: reset must act on its own
    task automatic trst_pulse();
        trst_n = 1'b0;
        repeat (4) @(posedge clk);
        #1 trst_n = 1'b1;
    endtask

    task automatic de_pulse(input int n);
        de_drive_n = 1'b0;
        repeat (n) @(posedge clk);
        #1 de_drive_n = 1'b1;
    endtask
endmodule

// File: jtdp_pkg.sv
// jtdp_pkg: shared types and constants of the test access and debug event port.
// assumes a core clock well above the test clock, which is sampled rather than used as a clock.
package jtdp_pkg;

    // ==============================================================
    // tap controller states
    typedef enum logic [3:0] {
        TAP_RESET      = 4'hf,
        TAP_IDLE       = 4'hc,
        TAP_SEL_DR     = 4'h7,
        TAP_CAP_DR     = 4'h6,
        TAP_SHIFT_DR   = 4'h2,
        TAP_EXIT1_DR   = 4'h1,
        TAP_PAUSE_DR   = 4'h3,
        TAP_EXIT2_DR   = 4'h0,
        TAP_UPD_DR     = 4'h5,
        TAP_SEL_IR     = 4'h4,
        TAP_CAP_IR     = 4'he,
        TAP_SHIFT_IR   = 4'ha,
        TAP_EXIT1_IR   = 4'h9,
        TAP_PAUSE_IR   = 4'hb,
        TAP_EXIT2_IR   = 4'h8,
        TAP_UPD_IR     = 4'hd
    } jtdp_tap_t;

    // ==============================================================
    // instruction register
    localparam int          IR_W       = 4;
    localparam logic [3:0]  IR_CAPTURE = 4'h1;
    localparam logic [3:0]  IR_BYPASS  = 4'hf;
    localparam logic [3:0]  IR_DBG_REQ = 4'h7;
    localparam logic [3:0]  IR_DBG_CMD = 4'h8;

    // ==============================================================
    // data and timing
    localparam int          DR_W_DEF     = 24;
    localparam logic [1:0]  DE_PULSE_CYC = 2'h3;

endpackage

// File: jtdp_tap_fsm.sv
// jtdp_tap_fsm: sixteen-state test controller stepped by sampled test clock rises.
// assumes tms is valid and aligned with the tck_rise strobe from the control side.
`timescale 1ns/1ps
module jtdp_tap_fsm
    import jtdp_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    jtdp_tap_if.fsm  tap
);

    typedef struct packed {
        jtdp_tap_t state;
    } jtdp_fsm_st_t;

    jtdp_fsm_st_t s_q;
    jtdp_fsm_st_t s_d;

    // ==============================================================
    // next state
    always_comb begin
        s_d = s_q;
        if (!rstn || tap.trst) begin
            s_d.state = TAP_RESET;  // see R5
        end else if (tap.tck_rise) begin  // see R2
            unique case (s_q.state)  // see R12
                TAP_RESET:    s_d.state = tap.tms ? TAP_RESET    : TAP_IDLE;
                TAP_IDLE:     s_d.state = tap.tms ? TAP_SEL_DR   : TAP_IDLE;
                TAP_SEL_DR:   s_d.state = tap.tms ? TAP_SEL_IR   : TAP_CAP_DR;
                TAP_CAP_DR:   s_d.state = tap.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
                TAP_SHIFT_DR: s_d.state = tap.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
                TAP_EXIT1_DR: s_d.state = tap.tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
                TAP_PAUSE_DR: s_d.state = tap.tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
                TAP_EXIT2_DR: s_d.state = tap.tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
                TAP_UPD_DR:   s_d.state = tap.tms ? TAP_SEL_DR   : TAP_IDLE;
                TAP_SEL_IR:   s_d.state = tap.tms ? TAP_RESET    : TAP_CAP_IR;
                TAP_CAP_IR:   s_d.state = tap.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
                TAP_SHIFT_IR: s_d.state = tap.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
                TAP_EXIT1_IR: s_d.state = tap.tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
                TAP_PAUSE_IR: s_d.state = tap.tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
                TAP_EXIT2_IR: s_d.state = tap.tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
                TAP_UPD_IR:   s_d.state = tap.tms ? TAP_SEL_DR   : TAP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    assign tap.state = s_q.state;

    // ==============================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    trst_to_reset_a: assert property (tap.trst |=> s_q.state == TAP_RESET) // see R5
        else $error("test reset did not force the reset state");
    idle_entry_a: assert property (tap.tck_rise && !tap.trst && !tap.tms && s_q.state == TAP_RESET // see R2
        |=> s_q.state == TAP_IDLE)
        else $error("tms low in reset did not move to idle");
    shift_exit_a: assert property (tap.tck_rise && !tap.trst && tap.tms && s_q.state == TAP_SHIFT_DR // see R12
        |=> s_q.state == TAP_EXIT1_DR ##1 $stable(s_q.state))
        else $error("tms high in shift-dr did not move to exit1-dr");
    hold_no_edge_a: assert property (!tap.tck_rise && !tap.trst |=> $stable(s_q.state)) // see R2
        else $error("state moved without a test clock rise");

endmodule

// File: jtdp_tap_if.sv
// jtdp_tap_if: sampled test clock strobe, mode select and test reset into the
// tap state machine, and its state back out. all on the core clock.
`timescale 1ns/1ps
interface jtdp_tap_if;
    import jtdp_pkg::*;
    logic      tck_rise;
    logic      tms;
    logic      trst;
    jtdp_tap_t state;
    modport fsm (input tck_rise, input tms, input trst, output state);
    modport ctl (output tck_rise, output tms, output trst, input state);
endinterface

// File: jtdp_top.sv
// jtdp_top: test access port and debug event pin, all logic on the core clock.
// assumes tck runs at most a quarter of clk; test pins and debug pin are asynchronous.
// What this block does
// R1: test data in is captured on each rising test clock edge.
// R2: mode select is sampled on each rising test clock edge and steps the test controller.
// R3: test data out changes only on falling test clock edges.
// R4: test data out is driven only in shift-ir and shift-dr and floats otherwise.
// R5: test reset initialises the test controller without waiting for a test clock edge.
// R6: the outside controller must pulse test reset after power-up.
// R7: a debug event pin request makes the core finish its instruction, save state and enter debug mode.
// R8: entering debug mode drives the debug event pin low for three core clock cycles.
// R9: the debug event pin bypasses the tap; everything else goes through the tap.
// R10: debug commands and core readback travel through the tap without disturbing normal operation.
// R11: during device reset test data out floats and all other pins are inputs.
// R12: the test controller is the standard sixteen-state machine.
`timescale 1ns/1ps
module jtdp_top
    import jtdp_pkg::*;
#(
    parameter int DR_W = DR_W_DEF
)(
    input  wire logic            clk,
    input  wire logic            rstn,
    input  wire logic            tck,
    input  wire logic            tms,
    input  wire logic            tdi,
    input  wire logic            trst_n,
    output logic                 tdo,
    output logic                 tdo_oe,
    input  wire logic            debug_event_pin_in_n,
    output logic                 debug_event_pin_out_n,
    output logic                 debug_event_pin_oe,
    input  wire logic            core_in_debug,
    output logic                 core_halt_req,
    input  wire logic [DR_W-1:0] dbg_rsp_data,
    output logic                 dbg_cmd_valid,
    output logic [DR_W-1:0]      dbg_cmd_data
);

    typedef struct packed {
        logic [2:0]      tck_s;
        logic [1:0]      tms_s;
        logic [1:0]      tdi_s;
        logic [1:0]      trst_s;
        logic [1:0]      de_s;
        logic [IR_W-1:0] ir;
        logic [IR_W-1:0] ir_sh;
        logic [DR_W-1:0] dr_sh;
        logic            byp;
        logic            tdo;
        logic            tdo_oe;
        logic [1:0]      de_cnt;
        logic            de_out_n;
        logic            de_oe;
        logic            in_dbg_prev;
        logic            halt_req;
        logic            cmd_valid;
        logic [DR_W-1:0] cmd_data;
    } jtdp_st_t;

    jtdp_st_t   s_q;
    jtdp_st_t   s_d;
    jtdp_tap_if tap_bus ();

    logic tck_fall;
    logic de_req;

    // ==============================================================
    // sampled test pins toward the controller
    // each synchroniser is read at its second stage; tck edges compare its second and third stages
    assign tap_bus.tck_rise = s_q.tck_s[1] & ~s_q.tck_s[2];
    assign tck_fall         = ~s_q.tck_s[1] & s_q.tck_s[2];
    assign tap_bus.tms      = s_q.tms_s[1];
    assign tap_bus.trst     = ~s_q.trst_s[1];  // see R6
    assign de_req           = ~s_q.de_s[1];

    jtdp_tap_fsm jtdp_tap_fsm_inst (
        .clk  (clk),
        .rstn (rstn),
        .tap  (tap_bus.fsm)
    );

    // ==============================================================
    // next state
    always_comb begin
        s_d           = s_q;
        s_d.tck_s     = {s_q.tck_s[1:0], tck};
        s_d.tms_s     = {s_q.tms_s[0], tms};
        s_d.tdi_s     = {s_q.tdi_s[0], tdi};
        s_d.trst_s    = {s_q.trst_s[0], trst_n};
        s_d.de_s      = {s_q.de_s[0], debug_event_pin_in_n};
        s_d.cmd_valid = 1'b0;
        s_d.in_dbg_prev = core_in_debug;

        // ---- tap data path, rising edge: capture and shift
        if (tap_bus.tck_rise) begin
            unique case (tap_bus.state)
                TAP_CAP_IR:   s_d.ir_sh = IR_CAPTURE;
                TAP_SHIFT_IR: s_d.ir_sh = {s_q.tdi_s[1], s_q.ir_sh[IR_W-1:1]};  // see R1
                TAP_CAP_DR: begin
                    if (s_q.ir == IR_DBG_CMD) begin
                        s_d.dr_sh = dbg_rsp_data;  // see R10
                    end else begin
                        s_d.byp = 1'b0;
                    end
                end
                TAP_SHIFT_DR: begin
                    if (s_q.ir == IR_DBG_CMD) begin
                        s_d.dr_sh = {s_q.tdi_s[1], s_q.dr_sh[DR_W-1:1]};  // see R1
                    end else begin
                        s_d.byp = s_q.tdi_s[1];  // see R1
                    end
                end
                default: ;
            endcase
        end

        // ---- falling edge: update stages and the output pin
        if (tck_fall) begin
            if (tap_bus.state == TAP_UPD_IR) begin
                s_d.ir = s_q.ir_sh;
                if (s_q.ir_sh == IR_DBG_REQ && !core_in_debug) begin
                    s_d.halt_req = 1'b1;  // see R10
                end
            end
            if (tap_bus.state == TAP_UPD_DR && s_q.ir == IR_DBG_CMD) begin
                s_d.cmd_valid = 1'b1;  // see R10
                s_d.cmd_data  = s_q.dr_sh;
            end
            // pin changes only here, so the far end samples a settled bit on its rise
            s_d.tdo    = (tap_bus.state == TAP_SHIFT_IR) ? s_q.ir_sh[0] :
                         (s_q.ir == IR_DBG_CMD)          ? s_q.dr_sh[0] : s_q.byp;  // see R3
            s_d.tdo_oe = (tap_bus.state == TAP_SHIFT_IR) ||
                         (tap_bus.state == TAP_SHIFT_DR);  // see R4
        end

        if (tap_bus.state == TAP_RESET) begin
            s_d.ir = IR_BYPASS;
        end
        if (tap_bus.trst) begin
            s_d.tdo_oe = 1'b0;  // see R5
        end

        // ---- debug event pin, outside the tap
        // own pulse reads back as a request, but the core is already in debug then
        if (core_in_debug) begin
            s_d.halt_req = 1'b0;
        end else if (de_req) begin
            s_d.halt_req = 1'b1;  // see R7 see R9
        end
        if (core_in_debug && !s_q.in_dbg_prev) begin
            s_d.de_cnt   = DE_PULSE_CYC;  // see R8
            s_d.de_out_n = 1'b0;
            s_d.de_oe    = 1'b1;
        end else if (s_q.de_cnt != 2'h0) begin
            s_d.de_cnt = s_q.de_cnt - 2'h1;
            if (s_q.de_cnt == 2'h1) begin
                s_d.de_out_n = 1'b1;  // see R8
                s_d.de_oe    = 1'b0;
            end
        end

        if (!rstn) begin
            s_d          = '0;  // see R11
            s_d.tck_s    = 3'h0;
            s_d.tms_s    = 2'h3;
            s_d.tdi_s    = 2'h3;
            s_d.de_s     = 2'h3;
            s_d.ir       = IR_BYPASS;
            s_d.tdo      = 1'b1;
            s_d.de_out_n = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    assign tdo                   = s_q.tdo;
    assign tdo_oe                = s_q.tdo_oe;
    assign debug_event_pin_out_n = s_q.de_out_n;
    assign debug_event_pin_oe    = s_q.de_oe;
    assign core_halt_req         = s_q.halt_req;
    assign dbg_cmd_valid         = s_q.cmd_valid;
    assign dbg_cmd_data          = s_q.cmd_data;

    // ==============================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    tdo_fall_only_a: assert property ($changed(tdo) |-> $past(tck_fall)) // see R3
        else $error("tdo changed away from a test clock fall");
    tdo_shift_on_a: assert property (tck_fall && !tap_bus.trst && tap_bus.state == TAP_SHIFT_DR // see R4
        |=> tdo_oe)
        else $error("tdo not driven in shift-dr");
    tdo_float_a: assert property (tck_fall && tap_bus.state == TAP_IDLE |=> !tdo_oe) // see R4
        else $error("tdo driven outside shift states");
    trst_float_a: assert property (tap_bus.trst |=> !tdo_oe) // see R5
        else $error("tdo driven under test reset");
    ir_shift_in_a: assert property (tap_bus.tck_rise && tap_bus.state == TAP_SHIFT_IR // see R1
        |=> s_q.ir_sh[IR_W-1] == $past(s_q.tdi_s[1]))
        else $error("tdi not captured into instruction shift");
    de_pulse_a: assert property ($rose(core_in_debug) && s_q.de_cnt == 2'h0 // see R8
        |=> (!debug_event_pin_out_n && debug_event_pin_oe) [*3] ##1 !debug_event_pin_oe)
        else $error("debug event pulse not three cycles");
    de_halt_a: assert property (de_req && !core_in_debug |=> core_halt_req) // see R7
        else $error("debug event request not passed to core");
    cmd_update_a: assert property (tck_fall && tap_bus.state == TAP_UPD_DR && s_q.ir == IR_DBG_CMD // see R10
        |=> dbg_cmd_valid ##1 !dbg_cmd_valid)
        else $error("debug command not issued on update-dr");
    // must run while rstn is low, so the default disable is overridden here
    reset_quiet_a: assert property (disable iff (1'b0) !rstn |=> !tdo_oe && !debug_event_pin_oe) // see R11
        else $error("pins driven during device reset");

    shift_dr_c: cover property (tap_bus.state == TAP_SHIFT_DR && tdo_oe);
    de_pulse_c: cover property ($rose(debug_event_pin_oe));
    cmd_c:      cover property (dbg_cmd_valid);
    halt_c:     cover property ($rose(core_halt_req));

endmodule
